/* File: shared/gbmmu_pkg.sv */
// shared constants and carrier types for the graphics bus translation unit
package gbmmu_pkg;
   // ==========================================================
   // geometry
   localparam int GBMMU_VA_W = 32; // virtual address width
   localparam int GBMMU_PA_W = 32; // physical address width
   localparam int GBMMU_PAGE_BYTES = 4096; // one entry covers 4KB
   localparam int GBMMU_OFS_W = $clog2(GBMMU_PAGE_BYTES); // 12 offset bits
   localparam int GBMMU_VPN_W = GBMMU_VA_W - GBMMU_OFS_W;
   localparam int GBMMU_PPN_W = GBMMU_PA_W - GBMMU_OFS_W;
   localparam int GBMMU_NREQ = 7; // parallel request sources
   localparam int GBMMU_CNT_W = 3; // outstanding-miss counter width
   localparam int GBMMU_ENTRIES = 8; // cached translations
   localparam int GBMMU_PTE_BYTES = 4; // table entry size in memory
   // reset values
   localparam logic [GBMMU_CNT_W-1:0] GBMMU_CNT_RST = 3'h0;
   localparam logic [GBMMU_NREQ-1:0] GBMMU_MASK_RST = 7'h00;
   localparam logic [GBMMU_PA_W-1:0] GBMMU_BASE_DEF = 32'h0000_0000;

   // ==========================================================
   // phase of the unit, one-hot
   typedef enum logic [1:0] {
      GBMMU_NORMAL = 2'b01,
      GBMMU_MISS = 2'b10
   } gbmmu_phase_t;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic valid;
      logic [GBMMU_VA_W-1:0] vaddr;
   } gbmmu_req_t;

   typedef struct packed {
      logic valid;
      logic [GBMMU_PA_W-1:0] paddr;
   } gbmmu_rsp_t;

   typedef struct packed {
      logic valid;
      logic [GBMMU_PA_W-1:0] addr;
   } gbmmu_fetch_t;
endpackage

/* File: logic/gbmmu_tlb.sv */
// translation cache: fully associative entries, round-robin replacement
module gbmmu_tlb
   import gbmmu_pkg::*;
#(
   parameter int ENTRIES = GBMMU_ENTRIES,
   parameter int NREQ = GBMMU_NREQ
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [NREQ*GBMMU_VPN_W-1:0] look_vpn,
   output logic [NREQ-1:0] look_hit,
   output logic [NREQ*GBMMU_PPN_W-1:0] look_ppn,
   input wire logic fill_en,
   input wire logic [GBMMU_VPN_W-1:0] fill_vpn,
   input wire logic [GBMMU_PPN_W-1:0] fill_ppn,
   input wire logic flush
);
   localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

   // ==========================================================
   // state
   typedef struct packed {
      logic [ENTRIES-1:0] vld;
      logic [ENTRIES-1:0][GBMMU_VPN_W-1:0] tag;
      logic [ENTRIES-1:0][GBMMU_PPN_W-1:0] ppn;
      logic [IW-1:0] victim;
   } gbmmu_tlb_st_t;

   gbmmu_tlb_st_t st_q; // registered cache
   gbmmu_tlb_st_t st_d; // next value

   // ==========================================================
   // compare every source against every entry (see R03)
   genvar g;
   generate
      for (g = 0; g < NREQ; g++) begin : g_look
         logic [GBMMU_VPN_W-1:0] vpn;
         logic hit;
         logic [GBMMU_PPN_W-1:0] ppn;
         assign vpn = look_vpn[g*GBMMU_VPN_W +: GBMMU_VPN_W];
         always_comb begin
            hit = 1'b0;
            ppn = '0;
            for (int e = 0; e < ENTRIES; e++) begin
               // tags are unique, so an or-merge is a clean select
               if (st_q.vld[e] && st_q.tag[e] == vpn) begin
                  hit = 1'b1;
                  ppn = ppn | st_q.ppn[e];
               end
            end
         end
         assign look_hit[g] = hit;
         assign look_ppn[g*GBMMU_PPN_W +: GBMMU_PPN_W] = ppn;
      end
   endgenerate

   // ==========================================================
   // fill and flush; flush beats a same-cycle fill
   always_comb begin
      st_d = st_q;
      if (flush) begin
         st_d.vld = '0;
      end else if (fill_en) begin // see R05
         st_d.vld[st_q.victim] = 1'b1;
         st_d.tag[st_q.victim] = fill_vpn;
         st_d.ppn[st_q.victim] = fill_ppn;
         st_d.victim = (st_q.victim == IW'(ENTRIES - 1)) ? '0 :
            IW'(st_q.victim + 1'b1);
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // gbmmu_tlb

/* File: logic/gbmmu_top.sv */
// graphics bus translation unit: phases, miss tracking, table fetch
//
// Functional notes
// R01: translate per 4KB page, one entry each
// R02: fetch table entries only on demand
// R03: cache entries, compare every request address
// R04: hit joins cached page with offset bits
// R05: miss reads entry, fills, then releases
// R06: seven parallel sources, all may miss
// R07: 3 bit counter tracks waiting misses
// R08: leave miss phase only at zero count
// R09: software idles core before invalidating cache
// R10: miss tracking never loses nor double-counts
module gbmmu_top
   import gbmmu_pkg::*;
#(
   parameter int NREQ = GBMMU_NREQ,
   parameter int ENTRIES = GBMMU_ENTRIES
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire gbmmu_req_t [NREQ-1:0] req, // per-source request, hold till ack
   output logic [NREQ-1:0] ack, // one-cycle pulse, answer taken
   output gbmmu_rsp_t [NREQ-1:0] rsp, // translated address with ack
   input wire logic [GBMMU_PA_W-1:0] table_base, // page table base
   input wire logic invalidate, // one-cycle flush request
   output gbmmu_fetch_t fetch, // table read request, held till done
   input wire logic fetch_done, // read data valid, one cycle
   input wire logic [GBMMU_PPN_W-1:0] fetch_ppn, // entry read back
   output logic miss_phase, // high while misses are serviced
   output logic [GBMMU_CNT_W-1:0] miss_count // waiting misses
);
   // ==========================================================
   // state
   typedef struct packed {
      gbmmu_phase_t phase;
      logic [NREQ-1:0] pend; // one flag per missing source
      logic [GBMMU_CNT_W-1:0] cnt; // outstanding misses
      logic busy; // table read in flight
      logic [$clog2(NREQ)-1:0] cur; // source being serviced
      logic [GBMMU_VPN_W-1:0] cur_vpn;
      gbmmu_fetch_t fetch;
      logic [NREQ-1:0] ack;
      gbmmu_rsp_t [NREQ-1:0] rsp;
      logic [NREQ-1:0] ack_gap; // one idle cycle after each ack
   } gbmmu_st_t;

   gbmmu_st_t st_q;
   gbmmu_st_t st_d;

   logic [NREQ*GBMMU_VPN_W-1:0] look_vpn;
   logic [NREQ-1:0] look_hit;
   logic [NREQ*GBMMU_PPN_W-1:0] look_ppn;
   logic fill_en;
   logic [NREQ-1:0] new_miss; // first miss of a source
   logic [NREQ-1:0] served; // miss retired this cycle
   logic [NREQ-1:0] cand; // pending flags, the one in service included
   logic pick_ok;
   logic [$clog2(NREQ)-1:0] pick;

   // ==========================================================
   // lookup ports: virtual page number of each source
   genvar g;
   generate
      for (g = 0; g < NREQ; g++) begin : g_vpn
         // upper bits name the 4KB page, low bits pass through (see R01)
         assign look_vpn[g*GBMMU_VPN_W +: GBMMU_VPN_W] =
            req[g].vaddr[GBMMU_VA_W-1:GBMMU_OFS_W];
      end
   endgenerate

   gbmmu_tlb #(
      .ENTRIES(ENTRIES),
      .NREQ(NREQ)
   ) u_tlb (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .look_vpn(look_vpn),
      .look_hit(look_hit),
      .look_ppn(look_ppn),
      .fill_en(fill_en),
      .fill_vpn(st_q.cur_vpn),
      .fill_ppn(fetch_ppn),
      .flush(invalidate)
   );

   // the fill lands only when the outstanding read returns
   assign fill_en = st_q.busy && fetch_done;

   // ==========================================================
   // next pending source to service, lowest index first
   always_comb begin
      cand = st_q.pend;
      pick_ok = 1'b0;
      pick = '0;
      for (int i = NREQ - 1; i >= 0; i--) begin
         if (cand[i]) begin
            pick_ok = 1'b1;
            pick = ($clog2(NREQ))'(i);
         end
      end
   end

   // ==========================================================
   // main next-state process
   always_comb begin
      st_d = st_q;
      st_d.ack = '0;
      st_d.ack_gap = st_q.ack;
      new_miss = '0;
      served = '0;
      // every source is looked at each cycle, all may miss (see R06)
      for (int i = 0; i < NREQ; i++) begin
         st_d.rsp[i].valid = 1'b0;
         // a source is idle for a cycle after its ack, so a held
         // request is never answered twice
         if (req[i].valid && !st_q.ack[i] && !st_q.ack_gap[i]) begin
            if (look_hit[i] && !(fill_en && st_q.cur ==
                  ($clog2(NREQ))'(i) && st_q.pend[i])) begin
               // hit: cached page joined with offset (see R04)
               st_d.ack[i] = 1'b1;
               st_d.rsp[i].valid = 1'b1;
               st_d.rsp[i].paddr = {look_ppn[i*GBMMU_PPN_W +: GBMMU_PPN_W],
                  req[i].vaddr[GBMMU_OFS_W-1:0]};
               if (st_q.pend[i] && !(st_q.busy &&
                     st_q.cur == ($clog2(NREQ))'(i))) begin
                  // another fill covered it; retire without a read
                  served[i] = 1'b1;
               end
            end else if (!look_hit[i] && !st_q.pend[i]) begin
               // a source counts at most once until served (see R10)
               new_miss[i] = 1'b1;
            end
         end
      end
      // retire the serviced miss when its read returns (see R05)
      if (fill_en) begin
         served[st_q.cur] = 1'b1;
         st_d.busy = 1'b0;
         st_d.fetch.valid = 1'b0;
      end
      st_d.pend = (st_q.pend | new_miss) & ~served;
      // count = pending flags, so it can neither wrap nor leak (see R07)
      st_d.cnt = '0;
      for (int i = 0; i < NREQ; i++) begin
         st_d.cnt = st_d.cnt + GBMMU_CNT_W'(st_d.pend[i]); // see R10
      end
      // issue a demand read for the next waiting source (see R02)
      if (!st_d.busy && st_q.phase == GBMMU_MISS && pick_ok &&
            !served[pick]) begin
         st_d.busy = 1'b1;
         st_d.cur = pick;
         st_d.cur_vpn = st_q.pend[pick] ?
            req[pick].vaddr[GBMMU_VA_W-1:GBMMU_OFS_W] : st_q.cur_vpn;
         st_d.fetch.valid = 1'b1;
         st_d.fetch.addr = table_base +
            GBMMU_PA_W'({req[pick].vaddr[GBMMU_VA_W-1:GBMMU_OFS_W], 2'b00});
      end
      // phase control (see R08)
      case (st_q.phase)
         GBMMU_NORMAL: begin
            if (|new_miss) begin
               st_d.phase = GBMMU_MISS;
            end
         end
         GBMMU_MISS: begin
            // only back to normal once nothing is waiting or in flight
            if (st_q.cnt == GBMMU_CNT_RST && !st_q.busy &&
                  st_d.cnt == GBMMU_CNT_RST) begin
               st_d.phase = GBMMU_NORMAL;
            end
         end
         default: begin
            st_d.phase = GBMMU_NORMAL;
         end
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
         st_q.phase <= GBMMU_NORMAL;
      end else begin
         st_q <= st_d;
      end
   end

   assign ack = st_q.ack;
   assign rsp = st_q.rsp;
   assign fetch = st_q.fetch;
   // one-hot code: the miss bit itself, straight from the flop
   assign miss_phase = st_q.phase[1];
   assign miss_count = st_q.cnt;

   // ==========================================================
   // assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   count_match_a: assert property ( // see R07
      miss_count == GBMMU_CNT_W'($countones(st_q.pend)))
      else $error("miss count differs from pending set");
   leave_zero_a: assert property ( // see R08
      $fell(miss_phase) |-> $past(miss_count) == 3'h0)
      else $error("miss phase left with misses waiting");
   fetch_hold_a: assert property ( // see R05
      fetch.valid && !fetch_done |=> fetch.valid && $stable(fetch.addr))
      else $error("table read dropped before done");
   demand_only_a: assert property ( // see R02
      $rose(fetch.valid) |-> miss_phase && $past(miss_count) != 3'h0)
      else $error("table read without a waiting miss");
   join_offset_a: assert property ( // see R04
      rsp[0].valid |-> rsp[0].paddr[GBMMU_OFS_W-1:0] ==
      $past(req[0].vaddr[GBMMU_OFS_W-1:0]))
      else $error("offset bits not passed through");
   no_ack_pend_a: assert property ( // see R05
      st_q.pend[0] && st_q.busy && st_q.cur == 3'h0 |-> !st_d.ack[0])
      else $error("stalled access released early");
   ack_pulse_a: assert property ( // see R10
      ack[1] |=> !ack[1])
      else $error("ack longer than one cycle");
   enter_miss_a: assert property ( // see R06
      !miss_phase && |new_miss |=> miss_phase && miss_count != 3'h0)
      else $error("miss did not enter miss phase");
   no_wrap_a: assert property ( // see R10
      miss_count <= 3'(NREQ))
      else $error("miss counter out of range");

   all_miss_c: cover property (miss_count == 3'h7);
   phase_cycle_c: cover property (miss_phase ##[1:200] !miss_phase);
   fill_c: cover property (fetch_done && fetch.valid);
endmodule // gbmmu_top

/* File: bench/gbmmu_mem_model.sv */
// external table memory model answering translation entry reads
module gbmmu_mem_model
   import gbmmu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire gbmmu_fetch_t fetch,
   input wire logic [3:0] lag,
   output logic fetch_done,
   output logic [GBMMU_PPN_W-1:0] fetch_ppn,
   output int n_reads
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // state
   logic [3:0] wait_cnt; // cycles the current read has waited
   // ==========================================================
   // read engine: table word at address a holds page ~a[21:2]
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wait_cnt <= 4'h0;
         fetch_done <= 1'b0;
         fetch_ppn <= 20'h5A5A5;
         // read tally restarts with the unit, callers take deltas
         n_reads <= 0;
      end else begin
         fetch_done <= 1'b0;
         // released data toggles so a stale word never looks valid
         fetch_ppn <= ~fetch_ppn;
         if (fetch_done) begin
            // requester drops its read on this edge, do not restart
            wait_cnt <= 4'h0;
         end else if (fetch.valid) begin
            if (wait_cnt == lag) begin
               fetch_done <= 1'b1;
               fetch_ppn <= ~fetch.addr[21:2];
               n_reads <= n_reads + 1;
               wait_cnt <= 4'h0;
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end
      end
   end
endmodule // gbmmu_mem_model

/* File: bench/tb_top.sv */
// self-checking bench for the graphics bus translation unit
module tb_top
   import gbmmu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // signals
   localparam logic [31:0] BASE = 32'h0004_0000; // table base
   typedef struct {int s; logic [31:0] va; int reads; logic [3:0] lag;}
      gbmmu_row_t;
   logic ref_clk, rstn, invalidate, fetch_done, miss_phase;
   gbmmu_req_t [GBMMU_NREQ-1:0] req;
   logic [GBMMU_NREQ-1:0] ack, pend;
   gbmmu_rsp_t [GBMMU_NREQ-1:0] rsp;
   gbmmu_fetch_t fetch;
   logic [GBMMU_PPN_W-1:0] fetch_ppn;
   logic [GBMMU_CNT_W-1:0] miss_count, peak;
   logic [3:0] lag;
   int n_reads, bad_count, n_checks, cycles, r0;
   gbmmu_row_t rows[6] = '{
      '{0, 32'h0001_2345, 1, 4'h0}, '{1, 32'h0001_2FFF, 0, 4'h0},
      '{2, 32'h0001_3000, 1, 4'h6}, '{6, 32'h0001_3ABC, 0, 4'h6},
      '{3, 32'hFFFF_F001, 1, 4'hF}, '{5, 32'h0001_2000, 0, 4'h0}};
   // ==========================================================
   // design and far side
   gbmmu_top uut (.ref_clk(ref_clk), .rstn(rstn), .req(req), .ack(ack),
      .rsp(rsp), .table_base(BASE), .invalidate(invalidate),
      .fetch(fetch), .fetch_done(fetch_done), .fetch_ppn(fetch_ppn),
      .miss_phase(miss_phase), .miss_count(miss_count));
   gbmmu_mem_model u_mem (.ref_clk(ref_clk), .rstn(rstn), .fetch(fetch),
      .lag(lag), .fetch_done(fetch_done), .fetch_ppn(fetch_ppn),
      .n_reads(n_reads));
   // ==========================================================
   // clock and hang guard
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
   end
   // ==========================================================
   // helpers
   function automatic logic [31:0] exp_pa(logic [31:0] va);
      logic [31:0] ea; // table word address of this page
      ea = BASE + {va[31:12], 2'b00};
      return {~ea[21:2], va[11:0]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
         input string what);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one request, held until its ack; entered at a falling edge
   task automatic xfer(input int s, input logic [31:0] va, input int rd);
      int k;
      logic ph; // miss phase seen while waiting
      r0 = n_reads;
      k = 0;
      ph = 1'b0;
      req[s].vaddr = va;
      req[s].valid = 1'b1;
      do begin
         @(negedge ref_clk);
         k++;
         ph = ph | miss_phase;
      end while (ack[s] !== 1'b1 && k < 100);
      chk(rsp[s].valid, 1'b1, "rsp valid");
      chk(rsp[s].paddr, exp_pa(va), "paddr");
      req[s].valid = 1'b0;
      chk(32'(n_reads - r0), 32'(rd), "reads");
      if (rd == 0) chk(32'(k), 32'h1, "hit latency");
      else chk(ph, 1'b1, "miss phase");
      repeat (3) @(negedge ref_clk);
      chk({miss_phase, miss_count}, 4'h0, "idle");
   endtask
   task automatic complete_run();
      if (bad_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      rstn = 1'b0;
      invalidate = 1'b0;
      req = '0;
      lag = 4'h0;
      repeat (10) @(negedge ref_clk);
      chk({ack, fetch.valid, miss_phase, miss_count}, 12'h000,
         "reset");
      rstn = 1'b1;
      @(negedge ref_clk);
      // ordinary hits and misses, prompt and slow memory
      foreach (rows[i]) begin
         lag = rows[i].lag;
         xfer(rows[i].s, rows[i].va, rows[i].reads);
      end
      // all seven sources miss together on distinct pages
      lag = 4'h8;
      r0 = n_reads;
      pend = 7'h7F;
      peak = 3'h0;
      for (int s = 0; s < 7; s++) begin
         req[s].vaddr = 32'h00A0_0000 + (s << 12);
         req[s].valid = 1'b1;
      end
      for (int k = 0; k < 400 && pend != 7'h00; k++) begin
         @(negedge ref_clk);
         if (miss_count > peak) peak = miss_count;
         for (int s = 0; s < 7; s++) begin
            if (ack[s] === 1'b1 && pend[s]) begin
               chk(rsp[s].paddr, exp_pa(req[s].vaddr), "multi pa");
               req[s].valid = 1'b0;
               pend[s] = 1'b0;
            end
         end
      end
      chk(pend, 7'h00, "all answered");
      chk(peak, 3'h7, "peak count");
      chk(32'(n_reads - r0), 32'h7, "multi reads");
      repeat (3) @(negedge ref_clk);
      chk({miss_phase, miss_count}, 4'h0, "multi idle");
      // one source missing several times in a row
      lag = 4'h2;
      for (int j = 0; j < 3; j++) xfer(4, 32'h0B00_0000 + (j << 12), 1);
      xfer(4, 32'h0B00_2FFC, 0);
      // invalidate with the core idle, then the page is read again
      @(negedge ref_clk);
      invalidate = 1'b1;
      @(negedge ref_clk);
      invalidate = 1'b0;
      xfer(4, 32'h0B00_2000, 1);
      // reset in the middle of a miss empties the cache
      req[0].vaddr = 32'h0C00_0000;
      req[0].valid = 1'b1;
      repeat (3) @(negedge ref_clk);
      rstn = 1'b0;
      req[0].valid = 1'b0;
      @(negedge ref_clk);
      chk({ack, fetch.valid, miss_phase, miss_count}, 12'h000,
         "mid reset");
      rstn = 1'b1;
      @(negedge ref_clk);
      xfer(0, 32'h0B00_2000, 1);
      complete_run();
   end
endmodule // tb_top
